// [src/dct_timer.sv]
// Dual 8-bit timer pair that can be cascaded into one 16-bit timer.
//
// Overview of operation
// - Two 8-bit counters run separately or cascade into one 16-bit counter.
// - One-shot: start at zero, on match toggle output, request interrupt, halt.
// - Continuous: each match toggles output, requests interrupt, restarts from zero.
// - Free-run: match toggles and interrupts without clearing; counter wraps to zero.
// - Fixed PWM: period is full counter range; high width set by register.
// - Variable PWM: both counters make one 8-bit PWM, period and low width programmed.
// - Variable PWM uses counters separately; cascading is unavailable then.
// - Pulse measurement measures width and period of the event input.
// - Measurement: zero at start edge; at end edge capture value and interrupt.
// - Input capture stores the counter value held in the cycle of a detected edge, before that cycle's count.
// - Capture clear: on edge capture, interrupt, then restart from zero.
// - Capture free-run: on edge capture and interrupt, counter keeps running.
// - Each channel compares against a latched copy of its data register.
// - Data register holds the compare value in timing modes, returns capture in measuring modes.
// - Count clock is selectable among prescaler outputs.
// - Input filter removes high pulses, low pulses or both.
// - Timer output drives pin only while output enabled, overriding port direction.
`timescale 1ns/10ps
`include "dct_consts.svh"
module dct_timer #(
  parameter int PRESC_N = `DCT_PRESC_N,
  parameter logic [7:0] FILTER_LEN = 8'(`DCT_FILTER_LEN)
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [PRESC_N-1:0] prescTick,
  input wire logic [1:0] loClkSel,
  input wire logic [1:0] hiClkSel,
  input wire logic [2:0] loMode,
  input wire logic [2:0] hiMode,
  input wire logic pairCascade,
  input wire logic loStart,
  input wire logic hiStart,
  input wire logic [1:0] measureSel,
  input wire logic [1:0] captureEdgeSel,
  input wire logic [1:0] filterSel,
  input wire logic [7:0] timerLoDataWrite,
  input wire logic timerLoDataWrEn,
  input wire logic [7:0] timerHiDataWrite,
  input wire logic timerHiDataWrEn,
  input wire logic loOutEnable,
  input wire logic hiOutEnable,
  input wire logic eventInputPin,
  output logic [7:0] timerLoDataRead,
  output logic [7:0] timerHiDataRead,
  output logic loIrq,
  output logic hiIrq,
  output logic timerLoOutPin,
  output logic timerLoOutPinOe,
  output logic timerHiOutPin,
  output logic timerHiOutPinOe
);

  dct_pkg::dct_state_t s;
  dct_pkg::dct_state_t n;
  logic evLevel;
  logic evRise;
  logic evFall;
  logic loTick;
  logic hiTick;
  logic varPwm;
  logic wide;
  logic evStart;
  logic evEnd;
  logic evCap;
  dct_pkg::dct_mode_t loModeT;
  dct_pkg::dct_mode_t hiModeT;

  // Synchronised and filtered event input with edge pulses.
  dct_event_filter #(
    .FILTER_LEN(FILTER_LEN)
  ) u_filter (
    .ref_clk(ref_clk),
    .reset(reset),
    .pinIn(eventInputPin),
    .filterSel(filterSel),
    .level(evLevel),
    .rise(evRise),
    .fall(evFall)
  );

  // True for the modes in which the data register returns a captured count.
  function automatic logic isMeasure(input dct_pkg::dct_mode_t m);
    isMeasure = (m == dct_pkg::DCT_PULSE_MEASURE) || (m == dct_pkg::DCT_CAPTURE_CLEAR)
      || (m == dct_pkg::DCT_CAPTURE_FREE);
  endfunction

  // Next state of one counter unit, eight or sixteen bits wide.
  function automatic dct_pkg::dct_unit_t unitStep(
    input dct_pkg::dct_unit_t u,
    input dct_pkg::dct_mode_t m,
    input logic wideCnt,
    input logic tick,
    input logic startReq,
    input logic [15:0] dataVal,
    input logic eStart,
    input logic eEnd,
    input logic eCap
  );
    dct_pkg::dct_unit_t r;
    logic [15:0] mask;
    logic [15:0] inc;
    logic match;
    r = u;
    r.irq = 1'b0;
    mask = wideCnt ? `DCT_MASK16 : `DCT_MASK8;
    inc = (u.cnt + `DCT_ONE16) & mask;
    match = (u.cnt == (u.latch & mask));
    if (!startReq)
    begin
      r.run = 1'b0;
      r.halted = 1'b0;
      r.measuring = 1'b0;
      r.cnt = `DCT_ZERO16;
    end
    else if (!u.run)
    begin
      r.run = 1'b1;
      r.cnt = `DCT_ZERO16;
      r.latch = dataVal;
      r.halted = 1'b0;
      r.measuring = 1'b0;
    end
    else
    begin
      case (m)
        dct_pkg::DCT_ONE_SHOT:
        begin
          if (tick && !u.halted)
          begin
            if (match)
            begin
              r.out = !u.out;
              r.irq = 1'b1;
              r.halted = 1'b1;
            end
            else
            begin
              r.cnt = inc;
            end
          end
        end
        dct_pkg::DCT_CONTINUOUS:
        begin
          if (tick)
          begin
            if (match)
            begin
              r.out = !u.out;
              r.irq = 1'b1;
              r.cnt = `DCT_ZERO16;
              r.latch = dataVal;
            end
            else
            begin
              r.cnt = inc;
            end
          end
        end
        dct_pkg::DCT_FREE_RUN:
        begin
          if (tick)
          begin
            r.cnt = inc;
            if (match)
            begin
              r.out = !u.out;
              r.irq = 1'b1;
            end
            if (inc == `DCT_ZERO16)
            begin
              r.latch = dataVal;
            end
          end
        end
        dct_pkg::DCT_PWM_FIXED:
        begin
          if (tick)
          begin
            r.cnt = inc;
            if (inc == `DCT_ZERO16)
            begin
              r.latch = dataVal;
              r.irq = 1'b1;
            end
          end
          r.out = (r.cnt < (r.latch & mask));
        end
        dct_pkg::DCT_PULSE_MEASURE:
        begin
          if (tick && u.measuring)
          begin
            r.cnt = inc;
          end
          if (eEnd && u.measuring)
          begin
            r.capt = u.cnt;
            r.irq = 1'b1;
            r.measuring = 1'b0;
            r.cnt = `DCT_ZERO16;
          end
          if (eStart)
          begin
            r.cnt = `DCT_ZERO16;
            r.measuring = 1'b1;
          end
        end
        dct_pkg::DCT_CAPTURE_CLEAR:
        begin
          if (tick)
          begin
            r.cnt = inc;
          end
          if (eCap)
          begin
            r.capt = u.cnt;
            r.irq = 1'b1;
            r.cnt = `DCT_ZERO16;
          end
        end
        dct_pkg::DCT_CAPTURE_FREE:
        begin
          if (tick)
          begin
            r.cnt = inc;
          end
          if (eCap)
          begin
            r.capt = u.cnt;
            r.irq = 1'b1;
          end
        end
        default:
        begin
          r.irq = 1'b0;
        end
      endcase
    end
    return r;
  endfunction

  // Count clock choice, edge decoding and the whole next state.
  always_comb
  begin
    loModeT = dct_pkg::dct_mode_t'(loMode);
    hiModeT = dct_pkg::dct_mode_t'(hiMode);
    loTick = prescTick[loClkSel];
    hiTick = prescTick[hiClkSel];
    varPwm = (loModeT == dct_pkg::DCT_PWM_VARIABLE);
    wide = pairCascade && !varPwm;
    case (dct_pkg::dct_measure_t'(measureSel))
      dct_pkg::DCT_HIGH_WIDTH:
      begin
        evStart = evRise;
        evEnd = evFall;
      end
      dct_pkg::DCT_LOW_WIDTH:
      begin
        evStart = evFall;
        evEnd = evRise;
      end
      dct_pkg::DCT_CYCLE_RISE:
      begin
        evStart = evRise;
        evEnd = evRise;
      end
      default:
      begin
        evStart = evFall;
        evEnd = evFall;
      end
    endcase
    evCap = (captureEdgeSel[0] && evRise) || (captureEdgeSel[1] && evFall);
    n = s;
    if (timerLoDataWrEn)
    begin
      n.loData = timerLoDataWrite;
    end
    if (timerHiDataWrEn)
    begin
      n.hiData = timerHiDataWrite;
    end
    n.lo = unitStep(s.lo, loModeT, wide, loTick, loStart,
      wide ? {s.hiData, s.loData} : {`DCT_ZERO8, s.loData}, evStart, evEnd, evCap);
    n.hi = unitStep(s.hi, hiModeT, 1'b0, hiTick, hiStart && !wide,
      {`DCT_ZERO8, s.hiData}, evStart, evEnd, evCap);
    // Variable PWM: the low counter sets the period, the high counter the low width.
    if (varPwm)
    begin
      n.lo = s.lo;
      n.hi = s.hi;
      n.lo.irq = 1'b0;
      n.hi.irq = 1'b0;
      if (!loStart)
      begin
        n.lo.run = 1'b0;
        n.lo.cnt = `DCT_ZERO16;
        n.hi.cnt = `DCT_ZERO16;
      end
      else if (!s.lo.run)
      begin
        n.lo.run = 1'b1;
        n.lo.cnt = `DCT_ZERO16;
        n.hi.cnt = `DCT_ZERO16;
        n.lo.latch = {`DCT_ZERO8, s.loData};
        n.hi.latch = {`DCT_ZERO8, s.hiData};
        n.lo.out = 1'b0;
      end
      else if (loTick)
      begin
        if (s.lo.cnt == s.lo.latch)
        begin
          n.lo.cnt = `DCT_ZERO16;
          n.hi.cnt = `DCT_ZERO16;
          n.lo.latch = {`DCT_ZERO8, s.loData};
          n.hi.latch = {`DCT_ZERO8, s.hiData};
          n.lo.out = 1'b0;
          n.lo.irq = 1'b1;
        end
        else
        begin
          n.lo.cnt = s.lo.cnt + `DCT_ONE16;
          if (s.hi.cnt == s.hi.latch)
          begin
            n.lo.out = 1'b1;
          end
          else
          begin
            n.hi.cnt = s.hi.cnt + `DCT_ONE16;
          end
        end
      end
    end
    n.irqLo = n.lo.irq;
    n.irqHi = n.hi.irq;
    n.loPinOut = n.lo.out;
    n.loPinOe = loOutEnable && !isMeasure(loModeT);
    n.hiPinOut = n.hi.out;
    n.hiPinOe = hiOutEnable && !wide && !varPwm && !isMeasure(hiModeT);
    n.loRead = isMeasure(loModeT) ? n.lo.capt[7:0] : n.loData;
    if (wide)
    begin
      n.hiRead = isMeasure(loModeT) ? n.lo.capt[15:8] : n.hiData;
    end
    else
    begin
      n.hiRead = isMeasure(hiModeT) ? n.hi.capt[7:0] : n.hiData;
    end
  end

  // State register.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  // Every output is a field of the state register.
  assign timerLoDataRead = s.loRead;
  assign timerHiDataRead = s.hiRead;
  assign loIrq = s.irqLo;
  assign hiIrq = s.irqHi;
  assign timerLoOutPin = s.loPinOut;
  assign timerLoOutPinOe = s.loPinOe;
  assign timerHiOutPin = s.hiPinOut;
  assign timerHiOutPinOe = s.hiPinOe;

endmodule

// [src/dct_consts.svh]
// Constants of the dual cascadable timer: widths, masks, reset values and filter length.
`ifndef DCT_CONSTS_SVH
`define DCT_CONSTS_SVH
`define DCT_CNT_W 8
`define DCT_WIDE_W 16
`define DCT_MASK8 16'h00FF
`define DCT_MASK16 16'hFFFF
`define DCT_ZERO16 16'h0000
`define DCT_ONE16 16'h0001
`define DCT_ZERO8 8'h00
`define DCT_PRESC_N 4
`define DCT_FILTER_LEN 4
`endif

// [src/dct_pkg.sv]
// Types of the dual cascadable timer: modes, edge selections and state records.
`include "dct_consts.svh"
package dct_pkg;

  // Operating mode of one 8-bit timer, or of the pair when cascaded.
  typedef enum logic [2:0] {
    DCT_ONE_SHOT = 3'b000,
    DCT_CONTINUOUS = 3'b001,
    DCT_FREE_RUN = 3'b010,
    DCT_PWM_FIXED = 3'b011,
    DCT_PWM_VARIABLE = 3'b100,
    DCT_PULSE_MEASURE = 3'b101,
    DCT_CAPTURE_CLEAR = 3'b110,
    DCT_CAPTURE_FREE = 3'b111
  } dct_mode_t;

  // Which edges open and close a pulse measurement.
  typedef enum logic [1:0] {
    DCT_HIGH_WIDTH = 2'b00,
    DCT_LOW_WIDTH = 2'b01,
    DCT_CYCLE_RISE = 2'b10,
    DCT_CYCLE_FALL = 2'b11
  } dct_measure_t;

  // State of one counter unit.
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] latch;
    logic [15:0] capt;
    logic run;
    logic halted;
    logic measuring;
    logic out;
    logic irq;
  } dct_unit_t;

  // Whole state of the timer pair.
  typedef struct packed {
    dct_unit_t lo;
    dct_unit_t hi;
    logic [7:0] loData;
    logic [7:0] hiData;
    logic [7:0] loRead;
    logic [7:0] hiRead;
    logic loPinOut;
    logic loPinOe;
    logic hiPinOut;
    logic hiPinOe;
    logic irqLo;
    logic irqHi;
  } dct_state_t;

  // State of the event input synchroniser and noise filter.
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic level;
    logic [7:0] stable;
    logic rise;
    logic fall;
  } dct_filter_t;

endpackage

// [src/dct_event_filter.sv]
// Event input synchroniser, selectable pulse noise filter and edge detector.
`timescale 1ns/10ps
`include "dct_consts.svh"
module dct_event_filter #(
  parameter logic [7:0] FILTER_LEN = 8'(`DCT_FILTER_LEN)
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic pinIn,
  input wire logic [1:0] filterSel,
  output logic level,
  output logic rise,
  output logic fall
);

  dct_pkg::dct_filter_t s;
  dct_pkg::dct_filter_t n;
  logic needStable;

  // The second stage alone is examined; a change must persist when its direction is filtered.
  always_comb
  begin
    n = s;
    n.sync1 = pinIn;
    n.sync2 = s.sync1;
    n.rise = 1'b0;
    n.fall = 1'b0;
    needStable = s.sync2 ? filterSel[0] : filterSel[1];
    if (s.sync2 == s.level)
    begin
      n.stable = 8'h00;
    end
    else if (!needStable || (s.stable + 8'h01 >= FILTER_LEN))
    begin
      n.level = s.sync2;
      n.stable = 8'h00;
      n.rise = s.sync2;
      n.fall = !s.sync2;
    end
    else
    begin
      n.stable = s.stable + 8'h01;
    end
  end

  // State register.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s <= '0;
    end
    else
    begin
      s <= n;
    end
  end

  assign level = s.level;
  assign rise = s.rise;
  assign fall = s.fall;

endmodule

// [tb/dct_timer_properties.sv]
// Port checker of the dual cascadable timer.
`timescale 1ns/10ps
module dct_timer_checker #(
  parameter int PRESC_N = 4
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [PRESC_N-1:0] prescTick,
  input wire logic [2:0] loMode,
  input wire logic [2:0] hiMode,
  input wire logic pairCascade,
  input wire logic [7:0] timerLoDataWrite,
  input wire logic timerLoDataWrEn,
  input wire logic [7:0] timerHiDataWrite,
  input wire logic timerHiDataWrEn,
  input wire logic loOutEnable,
  input wire logic [7:0] timerLoDataRead,
  input wire logic [7:0] timerHiDataRead,
  input wire logic loIrq,
  input wire logic timerLoOutPin,
  input wire logic timerLoOutPinOe,
  input wire logic timerHiOutPinOe
);
  // All checks share the timer clock and its reset.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  oe_rise_a: assert property ($rose(timerLoOutPinOe) |-> $past(loOutEnable) || $past(loOutEnable, 2))
    else $error("lo pin driven without enable");
  meas_oe_a: assert property ((loMode >= 3'h5)[*3] |-> !timerLoOutPinOe)
    else $error("lo pin driven in measuring mode");
  casc_hioe_a: assert property (pairCascade[*3] |-> !timerHiOutPinOe)
    else $error("hi pin driven while cascaded");
  var_hioe_a: assert property ((loMode == 3'h4)[*3] |-> !timerHiOutPinOe)
    else $error("hi pin driven in variable PWM");
  irq_toggle_a: assert property (loIrq && loMode < 3'h3 && $stable(loMode)
    |-> timerLoOutPin != $past(timerLoOutPin)) else $error("interval match without output toggle");
  lo_read_a: assert property (timerLoDataWrEn && !loMode[2] ##1 !timerLoDataWrEn && !loMode[2]
    |=> timerLoDataRead == $past(timerLoDataWrite, 2)) else $error("lo read misses written data");
  hi_read_a: assert property (timerHiDataWrEn && !loMode[2] && !hiMode[2]
    ##1 !timerHiDataWrEn && !hiMode[2]
    |=> timerHiDataRead == $past(timerHiDataWrite, 2)) else $error("hi read misses written data");
  no_tick_a: assert property (!loMode[2] throughout (prescTick == '0)[*4] |-> !loIrq)
    else $error("interrupt without count clock");
endmodule
bind dct_timer dct_timer_checker #(.PRESC_N(PRESC_N)) chk (.ref_clk, .reset, .prescTick, .loMode, .hiMode,
  .pairCascade, .timerLoDataWrite, .timerLoDataWrEn, .timerHiDataWrite, .timerHiDataWrEn, .loOutEnable,
  .timerLoDataRead, .timerHiDataRead, .loIrq, .timerLoOutPin, .timerLoOutPinOe, .timerHiOutPinOe);

// [tb/dct_event_source.sv]
// Model of the external signal source on the event input pin.
`timescale 1ns/10ps
module dct_event_source (
  input wire logic ref_clk,
  input wire logic idleLvl,
  input wire logic [7:0] width,
  input wire logic go,
  output logic eventInputPin
);
  logic [7:0] left = 8'h00;
  // A request starts a pulse of the given length away from the idle level.
  always @(posedge ref_clk) left <= go ? width : (left != 8'h00 ? left - 8'h01 : 8'h00);
  assign eventInputPin = (left != 8'h00) ? !idleLvl : idleLvl;
endmodule

// [tb/tb.sv]
// Self-checking bench of the dual cascadable timer.
`timescale 1ns/10ps
module tb;
  typedef struct {logic [2:0] m; logic c; logic [1:0] s; logic [15:0] d; int p; int h;} dct_row_t;
  logic ref_clk = 0, reset = 1, pairCascade = 0, loStart = 0, hiStart = 0, timerLoDataWrEn = 0;
  logic timerHiDataWrEn = 0, loOutEnable = 0, hiOutEnable = 1, tickOn = 1, go = 0, idleLvl = 0;
  logic [1:0] loClkSel = 0, hiClkSel = 0, measureSel = 0, captureEdgeSel = 0, filterSel = 0;
  logic [2:0] loMode = 0, hiMode = 0;
  logic [3:0] prescTick = 0;
  logic [7:0] timerLoDataWrite = 0, timerHiDataWrite = 0, width = 0, tk = 0, a, b;
  logic [7:0] timerLoDataRead, timerHiDataRead;
  logic loIrq, hiIrq, timerLoOutPin, timerLoOutPinOe, timerHiOutPin, timerHiOutPinOe, eventInputPin;
  int err_count = 0, n_tests = 0, c;
  dct_row_t rows [6] = '{'{3'h1, 0, 2'h0, 16'h0009, 10, -1}, '{3'h1, 0, 2'h2, 16'h0003, 16, -1},
    '{3'h2, 0, 2'h0, 16'h0040, 256, -1}, '{3'h3, 0, 2'h0, 16'h0030, 256, 48},
    '{3'h4, 0, 2'h0, 16'h0513, 20, 14}, '{3'h1, 1, 2'h0, 16'h0105, 262, -1}};
  dct_timer uut (.ref_clk, .reset, .prescTick, .loClkSel, .hiClkSel, .loMode, .hiMode, .pairCascade,
    .loStart, .hiStart, .measureSel, .captureEdgeSel, .filterSel, .timerLoDataWrite, .timerLoDataWrEn,
    .timerHiDataWrite, .timerHiDataWrEn, .loOutEnable, .hiOutEnable, .eventInputPin, .timerLoDataRead,
    .timerHiDataRead, .loIrq, .hiIrq, .timerLoOutPin, .timerLoOutPinOe, .timerHiOutPin, .timerHiOutPinOe);
  dct_event_source src (.ref_clk, .idleLvl, .width, .go, .eventInputPin);
  // Clock of 50 ns period.
  initial forever #25 ref_clk = ~ref_clk;
  // Prescaler strobes: every cycle, every second, every fourth and every eighth cycle.
  always @(posedge ref_clk)
  begin
    #5;
    tk <= tk + 8'h01;
    prescTick <= tickOn ? {tk[2:0] == 3'h0, tk[1:0] == 2'h0, tk[0], 1'b1} : 4'h0;
  end
  task automatic step(int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask
  task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %0h seen %0h", nm, exp, got);
      err_count++;
    end
  endtask
  task automatic give_verdict;
    if (err_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(logic [15:0] d);
    {timerHiDataWrite, timerLoDataWrite} = d;
    {timerHiDataWrEn, timerLoDataWrEn} = 2'h3;
    step(1);
    {timerHiDataWrEn, timerLoDataWrEn} = 2'h0;
    step(1);
    check("data read", {timerHiDataRead, timerLoDataRead}, d);
  endtask
  task automatic measure(input logic hiSide, output int p, output int h);
    p = 0;
    h = 0;
    while ((hiSide ? hiIrq : loIrq) !== 1'b1 && p < 3000)
    begin
      @(posedge ref_clk);
      #1 p++;
    end
    p = 0;
    do
    begin
      @(posedge ref_clk);
      #1 p++;
      h += ((hiSide ? timerHiOutPin : timerLoOutPin) === 1'b1);
    end while ((hiSide ? hiIrq : loIrq) !== 1'b1 && p < 3000);
    #4;
  endtask
  task automatic cnt_irq(int n, output int k);
    k = 0;
    repeat (n)
    begin
      @(posedge ref_clk);
      #1 k += ((loIrq | hiIrq) === 1'b1);
    end
    #4;
  endtask
  task automatic pulse(logic lv, logic [7:0] w);
    idleLvl = lv;
    width = w;
    go = 1;
    step(1);
    go = 0;
  endtask
  task automatic getcap(output logic [7:0] r);
    int k;
    for (k = 0; k < 200 && loIrq !== 1'b1; k++) step(1);
    step(2);
    r = timerLoDataRead;
  endtask
  task automatic arm(logic [2:0] m);
    loStart = 0;
    step(2);
    loMode = m;
    loStart = 1;
    step(3);
  endtask
  // Stop the run if the sequence hangs.
  initial
  begin
    #(50 * 20000);
    err_count++;
    give_verdict;
  end
  // Main sequence: table rows, then the awkward cases.
  initial
  begin
    int p, h;
    step(5);
    reset = 0;
    loOutEnable = 1;
    step(1);
    foreach (rows[i])
    begin
      {loMode, hiMode, pairCascade, loClkSel, hiClkSel} = {rows[i].m, rows[i].m, rows[i].c, rows[i].s, rows[i].s};
      wr(rows[i].d);
      {loStart, hiStart} = 2'h3;
      measure(0, p, h);
      check("period", p, rows[i].p);
      if (rows[i].h >= 0) check("high time", h, rows[i].h);
      {loStart, hiStart, pairCascade, hiMode} = 0;
      step(2);
    end
    {loMode, hiMode} = {3'h0, 3'h3};
    wr(16'h2005);
    hiStart = 1;
    measure(1, p, h);
    check("hi period", p, 256);
    check("hi high time", h, 32);
    hiStart = 0;
    arm(3'h0);
    cnt_irq(60, c);
    check("one-shot irqs", c, 1);
    tickOn = 0;
    arm(3'h1);
    cnt_irq(30, c);
    check("stalled irqs", c, 0);
    tickOn = 1;
    captureEdgeSel = 2'h3;
    arm(3'h7);
    pulse(0, 20);
    getcap(a);
    getcap(b);
    check("free capture gap", 8'(b - a), 8'h14);
    arm(3'h6);
    pulse(0, 20);
    getcap(a);
    getcap(b);
    check("clear capture", b == 8'h13 || b == 8'h14, 1);
    arm(3'h5);
    pulse(0, 20);
    getcap(a);
    check("high width", a >= 8'h13 && a <= 8'h15, 1);
    check("measure oe", timerLoOutPinOe, 0);
    filterSel = 2'h1;
    arm(3'h6);
    pulse(0, 2);
    cnt_irq(20, c);
    check("high glitch", c, 0);
    filterSel = 2'h2;
    pulse(1, 0);
    cnt_irq(20, c);
    pulse(1, 2);
    cnt_irq(20, c);
    check("low glitch", c, 0);
    pulse(1, 12);
    cnt_irq(40, c);
    check("long low pulse", c, 2);
    arm(3'h1);
    loOutEnable = 0;
    step(4);
    check("oe off", timerLoOutPinOe, 0);
    loOutEnable = 1;
    step(4);
    check("oe on", timerLoOutPinOe, 1);
    reset = 1;
    step(2);
    check("outputs in reset", {loIrq, hiIrq, timerLoOutPinOe, timerLoDataRead}, 0);
    reset = 0;
    step(1);
    give_verdict;
  end
endmodule
